// >>> include/irq_ctrl_pkg.sv
// package for the twelve source interrupt controller
// assumes one core clock, machine cycle of four clocks, apb register access
package irq_ctrl_pkg;
	localparam int unsigned NUM_SRC = 12;
	localparam int unsigned CLK_PER_MC = 4;
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned CALL_MC = 4;
	localparam int unsigned WORST_MC = 12;
	localparam int unsigned WORST_CLK = WORST_MC * CLK_PER_MC;
	localparam logic [1:0] SAMPLE_PHASE = 2'h2;
	// register byte addresses
	localparam logic [7:0] ADDR_ENABLE = 8'h00;
	localparam logic [7:0] ADDR_PRIO = 8'h04;
	localparam logic [7:0] ADDR_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_WDCTL = 8'h0c;
	localparam logic [7:0] ADDR_TRIG = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_TMR2 = 8'h18;
	localparam logic [7:0] ADDR_SERIAL = 8'h1c;
	// field positions
	localparam int unsigned GIE_BIT = 31;
	localparam int unsigned WD_FLAG_BIT = 3;
	localparam int unsigned WD_EN_BIT = 4;
	localparam logic [12:0] ENABLE_RST = 13'h0;
	localparam logic [11:0] PRIO_RST = 12'h000;
	// source indices in fixed polling order
	localparam int unsigned S_EXT0 = 0;
	localparam int unsigned S_TMR0 = 1;
	localparam int unsigned S_EXT1 = 2;
	localparam int unsigned S_TMR1 = 3;
	localparam int unsigned S_SER0 = 4;
	localparam int unsigned S_TMR2 = 5;
	localparam int unsigned S_SER1 = 6;
	localparam int unsigned S_EXT2 = 7;
	localparam int unsigned S_WDOG = 11;
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam logic [15:0] VEC_STEP = 16'h0008;
	localparam logic [15:0] VEC_SER1 = 16'h003b;

	typedef struct packed {
		logic last_cycle;
		logic writes_irq_regs;
		logic is_interrupt_exit_insn;
		logic is_ret;
		logic call_done;
	} seq_status_t;

	typedef struct packed {
		logic call_req;
		logic [15:0] vector;
		logic [3:0] source;
	} call_req_t;
endpackage : irq_ctrl_pkg

// >>> logic/irq_ctrl.sv
// twelve source, two level interrupt controller with hardware long call request
// assumes sequencer reports instruction boundaries and finishes the call in four machine cycles
// Summary of operation
// - timer 0 and 1 overflow flags clear when their routine is vectored
// - timer 2 request ORs overflow and external event; neither cleared on vectoring
// - watchdog timeout sets control bit 3; requests only with extended enable bit 4
// - each serial port requests on receive or transmit done; hardware never clears
// - software may write every request flag, one makes a software request except on external 0 and 1 in level mode
// - per source enables; global enable gates all except power fail
// - two levels, high or low per source, no preemption by equal or lower
// - equal level ties resolve in fixed order, external 0 first, watchdog last
// - flags sampled, polled and resolved every machine cycle
// - call only if level free, last cycle, no enable write, not interrupt exit
// - pending requests are not latched; each poll is new
// - external 0 and 1 flags clear on vectoring only in edge mode
// - call pushes program counter, not status word, then loads vector
// - each of the twelve sources has its own fixed vector address
// - interrupt exit ends service; plain return leaves service state set
// - external inputs sampled at phase three; timer flags polled next cycle
// - call lasts four machine cycles, five minimum from flag to routine
// - worst case response twelve machine cycles with nothing else in service
// - edge inputs flag on high then low sample; hold each level one cycle
// - externals 2 to 5 edge only; hardware clear select clears on entry
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl
	import irq_ctrl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [5:0] ext_input_pin_n,
	input wire logic timer0_overflow,
	input wire logic timer1_overflow,
	input wire logic timer2_overflow,
	input wire logic timer2_external_event,
	input wire logic [1:0] receive_done,
	input wire logic [1:0] transmit_done,
	input wire logic watchdog_timeout,
	input wire logic power_fail_interrupt,
	input wire seq_status_t seq_status,
	output call_req_t call_out,
	output logic push_pc_no_status,
	output logic [1:0] in_service,
	output logic mc_phase_end
);

	////////////////////////////////////////////////////////////////////////////
	// machine cycle phase divider

	logic [1:0] phase_ff;
	logic mc_tick;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_ff <= 2'h0;
		end else begin
			phase_ff <= phase_ff + 2'h1;
		end
	end
	assign mc_tick = (phase_ff == 2'h3);
	assign mc_phase_end = mc_tick;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers run every clock; levels sampled only at phase three

	logic [5:0] pin_meta_ff;
	logic [5:0] pin_sync_ff;
	logic [5:0] pin_prev_ff;
	logic [5:0] pin_level_ff;
	logic sample_phase_three;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_ff <= 6'h3f;
			pin_sync_ff <= 6'h3f;
		end else begin
			pin_meta_ff <= ext_input_pin_n;
			pin_sync_ff <= pin_meta_ff;
		end
	end
	assign sample_phase_three = (phase_ff == SAMPLE_PHASE);
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev_ff <= 6'h3f;
			pin_level_ff <= 6'h3f;
		end else if (sample_phase_three) begin
			pin_prev_ff <= pin_level_ff;
			pin_level_ff <= pin_sync_ff;
		end
	end
	logic [5:0] fall_edge;
	// high in one sample, low in the next; pins must hold one machine cycle
	assign fall_edge = pin_prev_ff & ~pin_level_ff;

	////////////////////////////////////////////////////////////////////////////
	// software registers

	logic apb_wr;
	logic apb_rd;
	logic [12:0] enable_ff;
	logic [11:0] prio_ff;
	logic [1:0] trig_ff;
	logic [3:0] hw_clear_select_ff;
	logic wd_enable_ff;
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;
	assign pready = 1'b1;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			enable_ff <= ENABLE_RST;
			prio_ff <= PRIO_RST;
			trig_ff <= 2'h0;
			hw_clear_select_ff <= 4'h0;
			wd_enable_ff <= 1'b0;
		end else if (apb_wr) begin
			unique case (paddr)
				ADDR_ENABLE: begin
					enable_ff <= {pwdata[GIE_BIT], pwdata[11:0]};
				end
				ADDR_PRIO: begin
					prio_ff <= pwdata[11:0];
				end
				ADDR_TRIG: begin
					trig_ff <= pwdata[1:0];
					hw_clear_select_ff <= pwdata[7:4];
				end
				ADDR_WDCTL: begin
					wd_enable_ff <= pwdata[WD_EN_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// request flags

	logic [5:0] ext_flag_ff;
	logic [1:0] tmr01_flag_ff;
	logic [1:0] tmr2_flag_ff;
	logic [1:0] rx_flag_ff;
	logic [1:0] tx_flag_ff;
	logic wd_flag_ff;
	logic vector_taken;
	logic [11:0] win_onehot;

	// hardware clear on vectoring; a set in the same cycle wins
	logic [5:0] ext_clr;
	logic [1:0] tmr_clr;
	always_comb begin
		ext_clr = 6'h00;
		tmr_clr = 2'h0;
		if (vector_taken) begin
			ext_clr[0] = win_onehot[S_EXT0] & trig_ff[0];
			ext_clr[1] = win_onehot[S_EXT1] & trig_ff[1];
			ext_clr[5:2] = win_onehot[S_EXT2 +: 4] & hw_clear_select_ff;
			tmr_clr[0] = win_onehot[S_TMR0];
			tmr_clr[1] = win_onehot[S_TMR1];
		end
	end

	logic [5:0] ext_set;
	logic [5:0] level_follow;
	assign level_follow = {4'h0, ~trig_ff};
	always_comb begin
		ext_set = {fall_edge[5:2], 2'h0};
		for (int i = 0; i < 2; i++) begin
			// level mode follows the pin, edge mode takes the edge
			ext_set[i] = trig_ff[i] ? fall_edge[i] : ~pin_level_ff[i];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_flag_ff <= 6'h00;
		end else begin
			for (int i = 0; i < 6; i++) begin
				if (sample_phase_three && ext_set[i]) begin
					ext_flag_ff[i] <= 1'b1;
				end else if (level_follow[i] && sample_phase_three) begin
					ext_flag_ff[i] <= 1'b0;
				end else if (apb_wr && paddr == ADDR_FLAGS) begin
					ext_flag_ff[i] <= pwdata[i];
				end else if (ext_clr[i]) begin
					ext_flag_ff[i] <= 1'b0;
				end
			end
		end
	end

	logic [1:0] tmr_ovf;
	assign tmr_ovf = {timer1_overflow, timer0_overflow};
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr01_flag_ff <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				// overflow is posted at phase three, so it polls next cycle
				if (tmr_ovf[i]) begin
					tmr01_flag_ff[i] <= 1'b1;
				end else if (apb_wr && paddr == ADDR_FLAGS) begin
					tmr01_flag_ff[i] <= pwdata[8 + i];
				end else if (tmr_clr[i]) begin
					tmr01_flag_ff[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr2_flag_ff <= 2'h0;
		end else begin
			// never cleared by vectoring, software resolves the cause
			for (int i = 0; i < 2; i++) begin
				if (i == 0 ? timer2_overflow : timer2_external_event) begin
					tmr2_flag_ff[i] <= 1'b1;
				end else if (apb_wr && paddr == ADDR_TMR2) begin
					tmr2_flag_ff[i] <= pwdata[i];
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_flag_ff <= 2'h0;
			tx_flag_ff <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (receive_done[i]) begin
					rx_flag_ff[i] <= 1'b1;
				end else if (apb_wr && paddr == ADDR_SERIAL) begin
					rx_flag_ff[i] <= pwdata[2 * i];
				end
				if (transmit_done[i]) begin
					tx_flag_ff[i] <= 1'b1;
				end else if (apb_wr && paddr == ADDR_SERIAL) begin
					tx_flag_ff[i] <= pwdata[2 * i + 1];
				end
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wd_flag_ff <= 1'b0;
		end else if (watchdog_timeout) begin
			wd_flag_ff <= 1'b1;
		end else if (apb_wr && paddr == ADDR_WDCTL) begin
			wd_flag_ff <= pwdata[WD_FLAG_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// poll and priority resolution

	logic [11:0] raw_req;
	logic [11:0] gated_req;
	assign raw_req = {wd_flag_ff & wd_enable_ff, ext_flag_ff[5:2],
		rx_flag_ff[1] | tx_flag_ff[1],
		tmr2_flag_ff[0] | tmr2_flag_ff[1],
		rx_flag_ff[0] | tx_flag_ff[0],
		tmr01_flag_ff[1], ext_flag_ff[1], tmr01_flag_ff[0], ext_flag_ff[0]};
	assign gated_req = raw_req & enable_ff[11:0] & {NUM_SRC{enable_ff[12]}};

	logic [1:0] active_ff;
	logic [11:0] hi_req;
	logic [11:0] lo_req;
	logic [11:0] pick;
	logic win_hi;
	logic pf_pick;
	logic poll_valid;
	assign hi_req = gated_req & prio_ff;
	assign lo_req = gated_req & ~prio_ff;
	// power fail bypasses the global enable and takes the highest level
	assign pf_pick = power_fail_interrupt && !active_ff[1];
	assign win_hi = (hi_req != 12'h000) && !active_ff[1];
	assign pick = win_hi ? hi_req : lo_req;
	always_comb begin
		win_onehot = 12'h000;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (pick[i]) begin
				win_onehot = 12'h000;
				win_onehot[i] = 1'b1;
			end
		end
	end
	assign poll_valid = win_hi || ((lo_req != 12'h000) && active_ff == 2'h0);

	logic [3:0] win_idx;
	logic [15:0] win_vec;
	always_comb begin
		win_idx = 4'h0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (win_onehot[i]) begin
				win_idx = 4'(i);
			end
		end
		// serial 1 sits off the even stride
		if (win_idx == 4'(S_SER1)) begin
			win_vec = VEC_SER1;
		end else if (win_idx > 4'(S_SER1)) begin
			win_vec = VEC_BASE + VEC_STEP * {12'h000, win_idx + 4'h1};
		end else begin
			win_vec = VEC_BASE + VEC_STEP * {12'h000, win_idx};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// call generation, four machine cycle call window

	logic call_ok;
	logic [2:0] call_cnt_ff;
	// poll is fresh every machine cycle, nothing is remembered between polls
	assign call_ok = mc_tick && (call_cnt_ff == 3'h0) && seq_status.last_cycle
		&& !seq_status.writes_irq_regs && !seq_status.is_interrupt_exit_insn;
	assign vector_taken = call_ok && poll_valid && !pf_pick;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			call_cnt_ff <= 3'h0;
		end else if (call_ok && (poll_valid || pf_pick)) begin
			call_cnt_ff <= 3'(CALL_MC);
		end else if (mc_tick && call_cnt_ff != 3'h0) begin
			call_cnt_ff <= call_cnt_ff - 3'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			call_out <= '0;
			push_pc_no_status <= 1'b0;
		end else begin
			call_out.call_req <= call_ok && (poll_valid || pf_pick);
			push_pc_no_status <= call_ok && (poll_valid || pf_pick);
			if (call_ok && (poll_valid || pf_pick)) begin
				call_out.vector <= pf_pick ? VEC_BASE : win_vec;
				call_out.source <= pf_pick ? 4'hf : win_idx;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// in-service markers

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			active_ff <= 2'h0;
		end else if (call_ok && (win_hi || pf_pick)) begin
			active_ff[1] <= 1'b1;
		end else if (vector_taken) begin
			active_ff[0] <= 1'b1;
		end else if (seq_status.is_interrupt_exit_insn && seq_status.last_cycle && mc_tick) begin
			// plain return leaves markers alone
			if (active_ff[1]) begin
				active_ff[1] <= 1'b0;
			end else begin
				active_ff[0] <= 1'b0;
			end
		end
	end
	assign in_service = active_ff;

	////////////////////////////////////////////////////////////////////////////
	// apb read side

	always_comb begin
		prdata = 32'h0000_0000;
		pslverr = 1'b0;
		if (apb_rd) begin
			unique case (paddr)
				ADDR_ENABLE: prdata = {enable_ff[12], 19'h0, enable_ff[11:0]};
				ADDR_PRIO: prdata = {20'h00000, prio_ff};
				ADDR_FLAGS: prdata = {22'h0, tmr01_flag_ff, 2'h0, ext_flag_ff};
				ADDR_WDCTL: prdata = {27'h0, wd_enable_ff, wd_flag_ff, 3'h0};
				ADDR_TRIG: prdata = {24'h000000, hw_clear_select_ff, 2'h0, trig_ff};
				ADDR_STATUS: prdata = {14'h0, active_ff, win_vec[11:0], win_idx};
				ADDR_TMR2: prdata = {30'h0, tmr2_flag_ff};
				ADDR_SERIAL: prdata = {28'h0000000, tx_flag_ff[1], rx_flag_ff[1],
					tx_flag_ff[0], rx_flag_ff[0]};
				default: pslverr = 1'b1;
			endcase
		end
	end
endmodule : irq_ctrl
`default_nettype wire

// >>> verification/irq_ctrl_chk.sv
// port assertions for the interrupt controller
// assumes bind into irq_ctrl, one clock domain
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_chk
	import irq_ctrl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire seq_status_t seq_status,
	input wire call_req_t call_out,
	input wire logic push_pc_no_status,
	input wire logic [1:0] in_service,
	input wire logic mc_phase_end
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic cr;
	logic poll_ok;
	logic [15:0] exp_vec;
	assign cr = call_out.call_req;
	assign poll_ok = mc_phase_end && seq_status.last_cycle && !seq_status.writes_irq_regs
		&& !seq_status.is_interrupt_exit_insn;
	// serial port 1 slot skips one step, so the upper half is offset
	assign exp_vec = (call_out.source < 4'h6) ? 16'h0003 + {call_out.source, 3'h0}
		: 16'h000b + {call_out.source, 3'h0};
	//////////////////////////////////////////////////
	sequence mc_gap;
		!mc_phase_end [*3] ##1 mc_phase_end;
	endsequence
	sequence call_quiet;
		!cr [*8];
	endsequence
	AST_MC_PERIOD: assert property (mc_phase_end |=> mc_gap)
		else $error("machine cycle is not four clocks");
	AST_CALL_COND: assert property (cr |-> $past(poll_ok))
		else $error("call without a valid poll");
	AST_CALL_GAP: assert property (cr |=> call_quiet)
		else $error("call repeated inside call window");
	AST_VECTOR: assert property (cr && call_out.source != 4'hf |-> call_out.vector == exp_vec)
		else $error("wrong vector for source");
	AST_PUSH: assert property (push_pc_no_status == cr)
		else $error("push pulse not aligned with call");
	AST_SVC_RISE: assert property ($rose(in_service[0]) || $rose(in_service[1]) |-> cr || $past(cr))
		else $error("service marker set without call");
	AST_SVC_FALL: assert property ($fell(in_service[0]) || $fell(in_service[1]) |-> $past(seq_status.is_interrupt_exit_insn && mc_phase_end))
		else $error("service marker cleared without exit");
	AST_RET_KEEP: assert property (seq_status.is_ret && !seq_status.is_interrupt_exit_insn && mc_phase_end
		|=> (in_service & $past(in_service)) == $past(in_service))
		else $error("plain return ended service");
	AST_NO_PREEMPT: assert property (cr && call_out.source != 4'hf |-> !$past(in_service[1]))
		else $error("high level routine preempted");
endmodule : irq_ctrl_chk
bind irq_ctrl irq_ctrl_chk irq_ctrl_chk_i (.core_clk(core_clk), .rst_n(rst_n),
	.seq_status(seq_status), .call_out(call_out), .push_pc_no_status(push_pc_no_status),
	.in_service(in_service), .mc_phase_end(mc_phase_end));
`default_nettype wire

// >>> verification/seq_model.sv
// instruction sequencer model facing the controller
// assumes call_req arrives one clock after a machine cycle end
`timescale 1ns/10ps
`default_nettype none
module seq_model
	import irq_ctrl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic mc_phase_end,
	input wire call_req_t call_out,
	input wire logic [2:0] insn_mc,
	input wire logic [1:0] exit_kind,
	input wire logic wr_regs,
	output seq_status_t seq_status
);
	logic [2:0] left_ff;
	logic [2:0] call_ff;
	logic last;
	// instruction is frozen while the call runs, as the real core does
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			left_ff <= 3'h0;
			call_ff <= 3'h0;
		end else if (call_out.call_req) begin
			call_ff <= 3'(CALL_MC);
		end else if (mc_phase_end) begin
			if (call_ff != 3'h0) call_ff <= call_ff - 3'h1;
			else left_ff <= (left_ff == 3'h0) ? insn_mc - 3'h1 : left_ff - 3'h1;
		end
	end
	assign last = (call_ff == 3'h0) && (left_ff == 3'h0);
	assign seq_status.last_cycle = last;
	assign seq_status.writes_irq_regs = last && wr_regs;
	assign seq_status.is_interrupt_exit_insn = last && (exit_kind == 2'h1);
	assign seq_status.is_ret = last && (exit_kind == 2'h2);
	assign seq_status.call_done = call_ff == 3'h1;
endmodule : seq_model
`default_nettype wire

// >>> verification/irq_ctrl_tb_top.sv
// self-checking bench for the interrupt controller
// assumes 50 MHz clock, zero wait apb slave, sequencer model
`timescale 1ns/10ps
`default_nettype none
module irq_ctrl_tb_top
	import irq_ctrl_pkg::*;
;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [5:0] pin_n = 6'h3f;
	logic [11:0] pulse = 12'h000;
	logic [3:0] xpulse = 4'h0;
	logic [2:0] insn_mc = 3'h1;
	logic [1:0] exit_kind = 2'h0;
	logic wr_regs = 1'b0;
	seq_status_t seq_status;
	call_req_t call_out;
	logic push_pc;
	logic [1:0] in_service;
	logic mc_end;
	logic [31:0] rd;
	logic se;
	int err_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int seed = 97464;
	int cur;
	int q_exp[$];
	logic [7:0] fa [12] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h1c, 8'h18, 8'h1c, 8'h08, 8'h08,
		8'h08, 8'h08, 8'h0c};
	logic [11:0] keep = 12'h870;
	irq_ctrl irq_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_input_pin_n(pin_n), .timer0_overflow(pulse[1]),
		.timer1_overflow(pulse[3]), .timer2_overflow(pulse[5]),
		.timer2_external_event(xpulse[0]), .receive_done({pulse[6], pulse[4]}),
		.transmit_done({xpulse[2], xpulse[1]}), .watchdog_timeout(pulse[11]),
		.power_fail_interrupt(xpulse[3]), .seq_status(seq_status),
		.call_out(call_out), .push_pc_no_status(push_pc), .in_service(in_service),
		.mc_phase_end(mc_end));
	seq_model seq_model_i (.core_clk(core_clk), .rst_n(rst_n), .mc_phase_end(mc_end),
		.call_out(call_out), .insn_mc(insn_mc), .exit_kind(exit_kind), .wr_regs(wr_regs),
		.seq_status(seq_status));
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			test_done();
		end
	end
	//////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : test_done
	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("Error %0t: %s", $time, m);
		end
	endtask : chk
	function automatic logic [15:0] vec(input int s);
		// power fail, code 15, shares the base vector
		return 16'(s == 15 ? 3 : s < 6 ? 3 + 8 * s : 11 + 8 * s);
	endfunction : vec
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic raise(input logic [11:0] m);
		@(posedge core_clk);
		pulse <= m & 12'h87a;
		pin_n <= ~{m[10:7], m[2], m[0]};
		@(posedge core_clk);
		pulse <= 12'h000;
	endtask : raise
	task automatic wait_call();
		int n;
		n = 0;
		while (call_out.call_req !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			n++;
		end
		pin_n <= 6'h3f;
		cur = q_exp.pop_front();
		chk(n < 400, "no call");
		chk(call_out.source === 4'(cur) && call_out.vector === vec(cur), "wrong call");
	endtask : wait_call
	task automatic quiet();
		int n;
		n = 0;
		repeat (120) begin
			@(posedge core_clk);
			if (call_out.call_req === 1'b1) n++;
		end
		chk(n == 0, "call while blocked");
	endtask : quiet
	// a plain return first, so service must survive it before the real exit
	task automatic finish(input int s);
		logic [1:0] sv;
		int n;
		apb(1'b0, fa[s], 32'h0);
		chk(((rd & ((s == 11) ? 32'h8 : 32'hffffffff)) != 0) === keep[s], "flag state");
		apb(1'b1, fa[s], (s == 11) ? 32'h10 : 32'h0);
		sv = in_service;
		exit_kind <= 2'h2;
		repeat (24) @(posedge core_clk);
		chk(in_service === sv, "plain return ended service");
		exit_kind <= 2'h1;
		n = 0;
		while (in_service === sv && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		exit_kind <= 2'h0;
		chk(in_service === (sv[1] ? {1'b0, sv[0]} : 2'h0), "exit marker");
	endtask : finish
	//////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		apb(1'b0, ADDR_ENABLE, 32'h0);
		chk(rd === 32'h0, "enable reset value");
		apb(1'b0, 8'h40, 32'h0);
		chk(se === 1'b1, "unmapped read");
		$display("test reset done");
		apb(1'b1, ADDR_WDCTL, 32'h10);
		apb(1'b1, ADDR_TRIG, 32'hf3);
		apb(1'b1, ADDR_ENABLE, 32'h80000fff);
		for (int s = 0; s < 12; s++) begin
			insn_mc <= 3'(1 + {$random(seed)} % 5);
			q_exp.push_back(s);
			raise(12'(1 << s));
			wait_call();
			finish(s);
		end
		// second cause of timer 2 and transmit side of both serial ports
		for (int k = 0; k < 3; k++) begin
			q_exp.push_back(k == 0 ? 5 : 2 + 2 * k);
			@(posedge core_clk);
			xpulse <= 4'(1 << k);
			@(posedge core_clk);
			xpulse <= 4'h0;
			wait_call();
			finish(cur);
		end
		$display("test vectors done");
		q_exp = '{3, 6, 11};
		raise(12'h848);
		repeat (3) begin
			wait_call();
			finish(cur);
		end
		$display("test order done");
		apb(1'b1, ADDR_PRIO, 32'h800);
		q_exp = '{1, 11};
		raise(12'h002);
		wait_call();
		raise(12'h800);
		wait_call();
		repeat (2) @(posedge core_clk);
		chk(in_service === 2'h3, "no preemption");
		finish(11);
		finish(1);
		$display("test levels done");
		apb(1'b1, ADDR_PRIO, 32'h0);
		apb(1'b1, ADDR_ENABLE, 32'h00000fff);
		raise(12'h002);
		quiet();
		wr_regs <= 1'b1;
		apb(1'b1, ADDR_ENABLE, 32'h80000fff);
		quiet();
		wr_regs <= 1'b0;
		q_exp = '{1, 1};
		wait_call();
		finish(1);
		$display("test gating done");
		apb(1'b1, ADDR_FLAGS, 32'h100);
		wait_call();
		finish(1);
		$display("test software flag done");
		// flag seen while blocked, gone when allowed: must not be served
		wr_regs <= 1'b1;
		apb(1'b1, ADDR_FLAGS, 32'h100);
		apb(1'b1, ADDR_FLAGS, 32'h0);
		wr_regs <= 1'b0;
		quiet();
		$display("test no latch done");
		apb(1'b1, ADDR_ENABLE, 32'h0);
		q_exp = '{15};
		xpulse <= 4'h8;
		wait_call();
		xpulse <= 4'h0;
		exit_kind <= 2'h1;
		repeat (24) @(posedge core_clk);
		exit_kind <= 2'h0;
		chk(in_service === 2'h0, "power fail exit");
		$display("test power fail done");
		test_done();
	end
endmodule : irq_ctrl_tb_top
`default_nettype wire
